/* mpc_pkg.sv */
// Purpose: shared constants and types for the playback control sequencer
// Assumes: one clock, sys_clk at 50 MHz, synchronous active-high reset
// Notes: register offsets are word indices on the plain register port
package mpc_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam logic [3:0] MPC_REG_CMD = 4'h0;
  localparam logic [3:0] MPC_REG_PORT1_CFG = 4'h1;
  localparam logic [3:0] MPC_REG_PORT2_CFG = 4'h2;
  localparam logic [3:0] MPC_REG_SYS_CFG = 4'h3;
  localparam logic [3:0] MPC_REG_STATUS = 4'h4;

  // serial port config fields
  localparam int MPC_PCFG_ACTIVE_BIT = 0;
  localparam int MPC_PCFG_SELECT_BIT = 1;
  // system config fields
  localparam int MPC_SYS_LASTPIC_BIT = 0;
  localparam int MPC_SYS_TYPE_LSB = 1;

  // reset values
  localparam logic [1:0] MPC_PCFG_RESET = 2'h0;
  localparam logic [2:0] MPC_SYS_RESET = 3'h0;

  // preamble layout
  localparam logic [31:0] MPC_PRE_CODE = 32'h000001FA;
  localparam logic [7:0] MPC_PRE_LEN = 8'h90;

  // stream kinds
  typedef enum logic [1:0] {
    MPC_ST_SYSTEM = 2'b00,
    MPC_ST_VIDEO = 2'b01,
    MPC_ST_AUDIO = 2'b10
  } mpc_stream_t;

  // on-line commands
  typedef enum logic [2:0] {
    MPC_CMD_NONE = 3'b000,
    MPC_CMD_GO = 3'b001,
    MPC_CMD_FREEZE = 3'b010,
    MPC_CMD_STEP = 3'b011,
    MPC_CMD_CONTINUE = 3'b100,
    MPC_CMD_END = 3'b101
  } mpc_cmd_t;

  typedef enum logic [2:0] {
    MPC_S_IDLE = 3'b000,
    MPC_S_SEARCH = 3'b001,
    MPC_S_PLAY = 3'b010,
    MPC_S_PAUSE = 3'b011,
    MPC_S_STEP = 3'b100,
    MPC_S_DRAIN = 3'b101
  } mpc_state_t;

  // events reported by the bitstream parser
  typedef struct packed {
    logic seq_header;
    logic i_picture;
    logic picture;
    logic pack_ok;
    logic preamble;
    logic iso_end;
    logic seq_end;
  } mpc_parse_t;

  // buffer and output status from the datapath
  typedef struct packed {
    logic video_full;
    logic audio_full;
    logic private_full;
    logic pictures_pending;
    logic serial_pending;
    logic data_seen;
  } mpc_buf_t;

endpackage

/* mpc_ctrl.sv */
// Purpose: playback command sequencer of an mpeg-1 system/video decoder
// Assumes: parser and buffer events come from logic on sys_clk
// Notes: commands are sampled at decode start times, except in idle, which takes go and drops the others at once
`timescale 1ns/1ps
`default_nettype none

module mpc_ctrl
  import mpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic decode_start,
  input wire logic init_done,
  input wire mpc_parse_t parse,
  input wire mpc_buf_t bufs,
  input wire logic audio_pkt,
  input wire logic private_pkt,
  output logic dma_request,
  output logic idle,
  output logic discard,
  output logic decode_en,
  output logic display_en,
  output logic show_last,
  output logic load_preamble,
  output logic serial_run,
  output logic port1_keep,
  output logic port2_keep
);

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  mpc_state_t state_q, state_d;
  mpc_cmd_t cmd_q, cmd_d;
  logic [1:0] port1_cfg_q, port1_cfg_d;
  logic [1:0] port2_cfg_q, port2_cfg_d;
  logic [2:0] sys_cfg_q, sys_cfg_d;
  logic endcmd_last_q, endcmd_last_d;
  logic req_stop_q, req_stop_d;
  logic hdr_seen_q, hdr_seen_d;
  logic show_last_q, show_last_d;
  logic [31:0] rdata_q, rdata_d;
  logic any_full, port1_select, port2_select;
  mpc_stream_t stype;

  assign stype = mpc_stream_t'(sys_cfg_q[MPC_SYS_TYPE_LSB +: 2]);
  assign port1_select = port1_cfg_q[MPC_PCFG_SELECT_BIT];
  assign port2_select = port2_cfg_q[MPC_PCFG_SELECT_BIT];
  assign any_full = bufs.video_full | bufs.audio_full | bufs.private_full;

  // ------------------------------------------------------------------
  // registers and sequencer next state
  // ------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cmd_d = cmd_q;
    port1_cfg_d = port1_cfg_q;
    port2_cfg_d = port2_cfg_q;
    sys_cfg_d = sys_cfg_q;
    endcmd_last_d = endcmd_last_q;
    req_stop_d = req_stop_q;
    hdr_seen_d = hdr_seen_q;
    show_last_d = show_last_q;
    rdata_d = 32'h0;
    // register writes; a command register write queues one command
    if (reg_wr) begin
      case (reg_addr)
        MPC_REG_CMD: begin
          cmd_d = mpc_cmd_t'(reg_wdata[2:0]);
          endcmd_last_d = reg_wdata[3];
        end
        MPC_REG_PORT1_CFG: port1_cfg_d = reg_wdata[1:0];
        MPC_REG_PORT2_CFG: port2_cfg_d = reg_wdata[1:0];
        MPC_REG_SYS_CFG: sys_cfg_d = reg_wdata[2:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        MPC_REG_CMD: rdata_d = {28'h0, endcmd_last_q, cmd_q};
        MPC_REG_PORT1_CFG: rdata_d = {30'h0, port1_cfg_q};
        MPC_REG_PORT2_CFG: rdata_d = {30'h0, port2_cfg_q};
        MPC_REG_SYS_CFG: rdata_d = {29'h0, sys_cfg_q};
        // bit5 tells software a sequence header was met in the search
        MPC_REG_STATUS: rdata_d = {26'h0, hdr_seen_q, dma_request, state_q,
                                   idle};
        default: rdata_d = 32'h0;
      endcase
    end
    // the stream's own end code (iso end for system, sequence end for video) stops requests in any state
    if ((stype == MPC_ST_SYSTEM && parse.iso_end) ||
        (stype == MPC_ST_VIDEO && parse.seq_end))
      req_stop_d = 1'b1;
    case (state_q)
      MPC_S_IDLE: begin
        // only go is valid here; others are dropped
        if (cmd_q != MPC_CMD_NONE && !reg_wr) begin
          if (cmd_q == MPC_CMD_GO) begin
            state_d = MPC_S_SEARCH;
            req_stop_d = 1'b0;
            hdr_seen_d = 1'b0;
          end
          cmd_d = MPC_CMD_NONE;
        end
      end
      MPC_S_SEARCH: begin
        // start-up point search per stream type
        if (parse.seq_header)
          hdr_seen_d = 1'b1;
        case (stype)
          MPC_ST_AUDIO: if (bufs.data_seen) state_d = MPC_S_PLAY;
          MPC_ST_VIDEO: if (parse.i_picture) state_d = MPC_S_PLAY;
          default: if (parse.pack_ok) state_d = MPC_S_PLAY;
        endcase
        // a write in the same cycle must not be lost to the sampling
        if (cmd_q == MPC_CMD_END && decode_start && !reg_wr) begin
          state_d = MPC_S_DRAIN;
          show_last_d = endcmd_last_q;
          cmd_d = MPC_CMD_NONE;
        end
      end
      MPC_S_PLAY, MPC_S_PAUSE: begin
        // queue sampled at decode start
        if (decode_start && cmd_q != MPC_CMD_NONE && !reg_wr) begin
          cmd_d = MPC_CMD_NONE;
          case (cmd_q)
            MPC_CMD_FREEZE: state_d = MPC_S_PAUSE;
            MPC_CMD_STEP:
              if (state_q == MPC_S_PAUSE) state_d = MPC_S_STEP;
            MPC_CMD_CONTINUE: state_d = MPC_S_PLAY;
            MPC_CMD_END: begin
              state_d = MPC_S_DRAIN;
              show_last_d = endcmd_last_q;
            end
            default: ;
          endcase
        end
        if (parse.seq_end || (stype == MPC_ST_SYSTEM && parse.iso_end)) begin
          state_d = MPC_S_DRAIN;
          show_last_d = sys_cfg_q[MPC_SYS_LASTPIC_BIT];
        end
      end
      MPC_S_STEP: begin
        // one picture decoded, then pause again
        if (parse.picture)
          state_d = MPC_S_PAUSE;
      end
      MPC_S_DRAIN: begin
        // idle only when display and serial are done
        if (!bufs.pictures_pending && !bufs.serial_pending)
          state_d = MPC_S_IDLE;
      end
      default: state_d = MPC_S_IDLE;
    endcase
    // end command also pre-empts a step in progress
    if (state_q == MPC_S_STEP && cmd_q == MPC_CMD_END && decode_start &&
        !reg_wr) begin
      state_d = MPC_S_DRAIN;
      show_last_d = endcmd_last_q;
      cmd_d = MPC_CMD_NONE;
    end
  end

  // register stage; init completion forces idle
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_q <= MPC_S_IDLE;
      cmd_q <= MPC_CMD_NONE;
      port1_cfg_q <= MPC_PCFG_RESET;
      port2_cfg_q <= MPC_PCFG_RESET;
      sys_cfg_q <= MPC_SYS_RESET;
      endcmd_last_q <= 1'b0;
      req_stop_q <= 1'b1;
      hdr_seen_q <= 1'b0;
      show_last_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      state_q <= init_done ? MPC_S_IDLE : state_d;
      cmd_q <= cmd_d;
      port1_cfg_q <= port1_cfg_d;
      port2_cfg_q <= port2_cfg_d;
      sys_cfg_q <= sys_cfg_d;
      endcmd_last_q <= endcmd_last_d;
      req_stop_q <= req_stop_d;
      hdr_seen_q <= hdr_seen_d;
      show_last_q <= show_last_d;
      rdata_q <= rdata_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // requests continue while paused until a buffer fills
  assign dma_request = (state_q != MPC_S_IDLE) && (state_q != MPC_S_DRAIN)
                       && !req_stop_q && !any_full;
  assign idle = (state_q == MPC_S_IDLE);
  assign reg_rdata = rdata_q;
  // everything before the start-up point is thrown away
  assign discard = (state_q == MPC_S_SEARCH);
  assign decode_en = (state_q == MPC_S_PLAY) || (state_q == MPC_S_STEP);
  // display enabled once past the start-up point
  assign display_en = (state_q != MPC_S_IDLE) && (state_q != MPC_S_SEARCH);
  assign show_last = show_last_q;
  // preamble loads stored parameters during search
  assign load_preamble = (state_q == MPC_S_SEARCH) && parse.preamble;
  // serial output tracks video pause and run
  assign serial_run = decode_en ||
                      (state_q == MPC_S_DRAIN && bufs.serial_pending);
  // route packets by select bit, keep only if active
  assign port1_keep = port1_cfg_q[MPC_PCFG_ACTIVE_BIT] &&
                      (port1_select ? private_pkt : audio_pkt);
  assign port2_keep = port2_cfg_q[MPC_PCFG_ACTIVE_BIT] &&
                      (port2_select ? private_pkt : audio_pkt);

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  sequence s_go_taken;
    state_q == MPC_S_IDLE && cmd_q == MPC_CMD_GO && !reg_wr;
  endsequence

  property p_go_search;
    @(posedge sys_clk) disable iff (sys_rst)
      (s_go_taken and !init_done) |=> state_q == MPC_S_SEARCH;
  endproperty
  a_go_search: assert property (p_go_search)
    else $error("go not taken in idle");

  property p_full_stops;
    @(posedge sys_clk) disable iff (sys_rst)
      any_full |-> !dma_request;
  endproperty
  a_full_stops: assert property (p_full_stops)
    else $error("request while buffer full");

  property p_pause_req;
    @(posedge sys_clk) disable iff (sys_rst)
      state_q == MPC_S_PAUSE && !req_stop_q && !any_full |-> dma_request;
  endproperty
  a_pause_req: assert property (p_pause_req)
    else $error("pause dropped request early");

  property p_end_code;
    @(posedge sys_clk) disable iff (sys_rst)
      stype == MPC_ST_VIDEO && parse.seq_end |=> !dma_request;
  endproperty
  a_end_code: assert property (p_end_code)
    else $error("request after end code");

  property p_drain_idle;
    @(posedge sys_clk) disable iff (sys_rst)
      state_q == MPC_S_DRAIN && (bufs.pictures_pending || bufs.serial_pending)
      && !init_done |=> !idle;
  endproperty
  a_drain_idle: assert property (p_drain_idle)
    else $error("idle before output drained");

  property p_serial_pause;
    @(posedge sys_clk) disable iff (sys_rst)
      state_q == MPC_S_PAUSE |-> !serial_run;
  endproperty
  a_serial_pause: assert property (p_serial_pause)
    else $error("serial runs while paused");

  property p_discard;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(state_q == MPC_S_SEARCH) |-> discard;
  endproperty
  a_discard: assert property (p_discard)
    else $error("search without discard");

  property p_port_off;
    @(posedge sys_clk) disable iff (sys_rst)
      !port1_cfg_q[MPC_PCFG_ACTIVE_BIT] |-> !port1_keep;
  endproperty
  a_port_off: assert property (p_port_off)
    else $error("inactive port kept data");

  property p_step_one;
    @(posedge sys_clk) disable iff (sys_rst)
      state_q == MPC_S_STEP && parse.picture && !init_done
      && !(cmd_q == MPC_CMD_END && decode_start) |=> state_q == MPC_S_PAUSE;
  endproperty
  a_step_one: assert property (p_step_one)
    else $error("step did not pause after picture");

endmodule

`default_nettype wire

/* mpc_host_model.sv */
// Purpose: bitstream source standing in for the host or dma controller
// Assumes: one transfer per cycle while requested and not stalled
// Notes: data_seen tells the sequencer that the stream buffer holds data
`timescale 1ns/1ps
`default_nettype none

module mpc_host_model (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic dma_request,
  input wire logic idle,
  input wire logic stall,
  output logic xfer,
  output logic data_seen
);
  logic seen_d;
  logic seen_q;

  // ------------------------------------------------------------------
  // transfer and buffer fill
  // ------------------------------------------------------------------
  // a byte moves only in a requested cycle, at the pace of the requests
  assign xfer = dma_request & ~stall;

  // buffer holds data once a byte arrived, emptied when playback stops
  always_comb begin
    seen_d = seen_q;
    if (xfer) begin
      seen_d = 1'b1;
    end
    if (idle) begin
      seen_d = 1'b0;
    end
  end

  // register the fill flag
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= seen_d;
    end
  end

  assign data_seen = seen_q;
endmodule
`default_nettype wire

/* mpc_ctrl_bench.sv */
// Purpose: self-checking bench for the playback command sequencer
// Assumes: host model answers each bitstream request while stall is low
// Notes: routing cases run from a table, the other cases by hand
`timescale 1ns/1ps
`default_nettype none

module mpc_ctrl_bench
  import mpc_pkg::*;
;
  logic sys_clk, sys_rst, reg_wr, reg_rd, decode_start, init_done;
  logic audio_pkt, private_pkt, stall, host_seen;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  mpc_parse_t parse;
  mpc_buf_t bf, bufs_w;
  logic dma_request, idle, discard, decode_en, display_en, show_last;
  logic load_preamble, serial_run, port1_keep, port2_keep;
  int err_count, n_tests, i;
  // p1 cfg, p2 cfg, audio, private, keep1, keep2
  logic [7:0] rows [6] = '{8'h7A, 8'h75, 8'h28, 8'h24, 8'hD9, 8'hD6};

  assign bufs_w = mpc_buf_t'({bf[5:1], host_seen});

  mpc_ctrl DUT (.sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .decode_start, .init_done, .parse,
    .bufs(bufs_w), .audio_pkt, .private_pkt, .dma_request, .idle,
    .discard, .decode_en, .display_en, .show_last, .load_preamble,
    .serial_run, .port1_keep, .port2_keep);

  mpc_host_model host (.sys_clk, .sys_rst, .dma_request, .idle, .stall,
    .xfer(), .data_seen(host_seen));

  // ------------------------------------------------------------------
  // clock, watchdog and helpers
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial begin
    #1000000;
    err_count++;
    give_verdict();
  end

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, e);
  endtask

  task automatic dstart();
    @(posedge sys_clk);
    decode_start <= 1'b1;
    @(posedge sys_clk);
    decode_start <= 1'b0;
  endtask

  task automatic ev(input mpc_parse_t p);
    @(posedge sys_clk);
    parse <= p;
    @(posedge sys_clk);
    parse <= '0;
  endtask

  task automatic go_cmd(input logic [31:0] sys);
    wr(MPC_REG_SYS_CFG, sys);
    wr(MPC_REG_CMD, 32'h1);
    cyc(3);
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {reg_wr, reg_rd, decode_start, init_done, audio_pkt} = '0;
    {private_pkt, stall} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    parse = '0;
    bf = '0;
    err_count = 0;
    n_tests = 0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    cyc(1);
    chk("idle", idle, 1);
    chk("dma_request", dma_request, 0);
    rd_chk(MPC_REG_STATUS, 32'h1);
    rd_chk(MPC_REG_PORT1_CFG, 32'h0);
    wr(4'hE, 32'h3);
    rd_chk(4'hE, 32'h0);
    // freeze while idle is dropped
    wr(MPC_REG_CMD, 32'h2);
    dstart();
    cyc(2);
    chk("idle", idle, 1);
    // system go, search then start at a qualifying pack
    go_cmd(32'h0);
    chk("idle", idle, 0);
    chk("discard", discard, 1);
    chk("dma_request", dma_request, 1);
    ev(7'h08);
    cyc(1);
    chk("decode_en", decode_en, 1);
    chk("display_en", display_en, 1);
    chk("discard", discard, 0);
    bf.audio_full <= 1'b1;
    cyc(2);
    chk("dma_request", dma_request, 0);
    bf.audio_full <= 1'b0;
    // routing table
    for (i = 0; i < 6; i++) begin
      wr(MPC_REG_PORT1_CFG, {30'h0, rows[i][7:6]});
      wr(MPC_REG_PORT2_CFG, {30'h0, rows[i][5:4]});
      audio_pkt <= rows[i][3];
      private_pkt <= rows[i][2];
      cyc(2);
      chk("port1_keep", port1_keep, rows[i][1]);
      chk("port2_keep", port2_keep, rows[i][0]);
      rd_chk(MPC_REG_PORT1_CFG, {30'h0, rows[i][7:6]});
    end
    // freeze waits for a decode start, requests go on until full
    wr(MPC_REG_CMD, 32'h2);
    cyc(3);
    chk("decode_en", decode_en, 1);
    dstart();
    cyc(2);
    chk("decode_en", decode_en, 0);
    chk("serial_run", serial_run, 0);
    chk("dma_request", dma_request, 1);
    bf.video_full <= 1'b1;
    cyc(2);
    chk("dma_request", dma_request, 0);
    bf.video_full <= 1'b0;
    // one step decodes a picture, continue resumes
    wr(MPC_REG_CMD, 32'h3);
    dstart();
    cyc(2);
    chk("decode_en", decode_en, 1);
    ev(7'h10);
    cyc(2);
    chk("decode_en", decode_en, 0);
    wr(MPC_REG_CMD, 32'h4);
    dstart();
    cyc(2);
    chk("serial_run", serial_run, 1);
    // natural end drains output, then idles showing the last picture
    wr(MPC_REG_SYS_CFG, 32'h1);
    bf.pictures_pending <= 1'b1;
    bf.serial_pending <= 1'b1;
    ev(7'h02);
    cyc(2);
    chk("dma_request", dma_request, 0);
    chk("idle", idle, 0);
    bf.pictures_pending <= 1'b0;
    bf.serial_pending <= 1'b0;
    cyc(3);
    chk("idle", idle, 1);
    chk("show_last", show_last, 1);
    // end command with its own last picture field
    go_cmd(32'h1);
    ev(7'h08);
    bf.pictures_pending <= 1'b1;
    wr(MPC_REG_CMD, 32'h5);
    dstart();
    cyc(2);
    chk("decode_en", decode_en, 0);
    chk("idle", idle, 0);
    bf.pictures_pending <= 1'b0;
    cyc(3);
    chk("idle", idle, 1);
    chk("show_last", show_last, 0);
    // video-only: serial ports off, preamble, header, then I-picture
    wr(MPC_REG_PORT1_CFG, 32'h0);
    wr(MPC_REG_PORT2_CFG, 32'h0);
    go_cmd(32'h2);
    @(posedge sys_clk);
    parse <= 7'h04;
    #1;
    chk("load_preamble", load_preamble, 1);
    ev(7'h40);
    cyc(1);
    chk("decode_en", decode_en, 0);
    rd_chk(MPC_REG_STATUS, 32'h32);
    ev(7'h20);
    cyc(1);
    chk("decode_en", decode_en, 1);
    ev(7'h01);
    cyc(3);
    chk("dma_request", dma_request, 0);
    chk("idle", idle, 1);
    // mid-stream entry starts at the I-picture, init forces idle
    go_cmd(32'h2);
    ev(7'h20);
    cyc(1);
    chk("decode_en", decode_en, 1);
    @(posedge sys_clk);
    init_done <= 1'b1;
    @(posedge sys_clk);
    init_done <= 1'b0;
    cyc(2);
    chk("idle", idle, 1);
    // audio-only: output starts once the stalled source delivers
    stall <= 1'b1;
    go_cmd(32'h4);
    chk("serial_run", serial_run, 0);
    stall <= 1'b0;
    for (i = 0; i < 40 && serial_run !== 1'b1; i++) begin
      cyc(1);
    end
    chk("serial_run", serial_run, 1);
    if (i == 40) begin
      give_verdict();
    end
    wr(MPC_REG_CMD, 32'h5);
    dstart();
    cyc(3);
    chk("idle", idle, 1);
    // reset in mid-run clears the queue, the ports and the request
    go_cmd(32'h0);
    wr(MPC_REG_PORT1_CFG, 32'h3);
    wr(MPC_REG_CMD, 32'h2);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    cyc(1);
    chk("idle", idle, 1);
    chk("dma_request", dma_request, 0);
    rd_chk(MPC_REG_CMD, 32'h0);
    rd_chk(MPC_REG_PORT1_CFG, 32'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
